// >>> sim/uchf_handler_test.sv
// self-checking bench of the under-current fault handler
`default_nettype none
`define CHK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: %s", $time, msg); end end

module uchf_handler_test
    import uchf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int          CU  = 20;
    localparam int          RU  = 16;
    localparam logic [15:0] LIM = 16'h0100;
    localparam logic [15:0] LOW = 16'h0010;
    localparam logic [15:0] HI  = 16'h0800;

    typedef struct {int kind; logic [15:0] val; string msg;} uchf_exp_t;

    logic        clk_sys_i;
    logic        sys_rst_i       = 1'b1;
    logic        cmd_wr_i        = 1'b0;
    uchf_cmd_t   cmd_i           = '0;
    logic [7:0]  rd_code_i       = 8'h00;
    logic        output_enable_i = 1'b1;
    logic        clear_faults_i  = 1'b0;
    logic [15:0] load            = 16'hFFFF;
    logic        att_clr         = 1'b0;
    logic        uc_fault, output_on_o, alert_output_n_o, uc_status_o, on_q;
    logic [15:0] rd_data_o, oc_warn_threshold_o, uc_threshold_o;
    logic [31:0] rnd, rnd2;
    int          err_total, checked, att;
    uchf_exp_t   exp_q[$];
    uchf_exp_t   e;
    logic [2:0]  rlist[9] = '{3'd0, 3'd1, 3'd2, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6, 3'd7};

    uchf_handler #(.CONT_UNIT_CYCLES(CU), .RETRY_UNIT_CYCLES(RU)) uchf_handler_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cmd_wr_i(cmd_wr_i), .cmd_i(cmd_i),
        .rd_code_i(rd_code_i), .rd_data_o(rd_data_o), .output_enable_i(output_enable_i),
        .uc_fault_i(uc_fault), .clear_faults_i(clear_faults_i), .output_on_o(output_on_o),
        .alert_output_n_o(alert_output_n_o), .uc_status_o(uc_status_o),
        .oc_warn_threshold_o(oc_warn_threshold_o), .uc_threshold_o(uc_threshold_o));

    uchf_load_model uchf_load_model_inst (
        .load_i(load), .uc_threshold_i(uc_threshold_o), .uc_fault_o(uc_fault));

    // ------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // restart attempts seen as rising edges of the output
    always @(posedge clk_sys_i) begin
        on_q <= output_on_o;
        if (att_clr) att <= 0;
        else if (output_on_o && !on_q) att <= att + 1;
    end

    function automatic logic [15:0] pick(int k);
        case (k)
            0: return rd_data_o;
            1: return {15'h0, output_on_o};
            2: return {15'h0, alert_output_n_o};
            3: return {15'h0, uc_status_o};
            4: return 16'(att);
            5: return {15'h0, att > 6};
            6: return oc_warn_threshold_o;
            default: return uc_threshold_o;
        endcase
    endfunction : pick

    always @(negedge clk_sys_i) begin
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK(pick(e.kind), e.val, e.msg)
        end
    end

    initial begin
        tick(20000);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick

    task automatic note(int kind, logic [15:0] val, string msg);
        exp_q.push_back('{kind, val, msg});
    endtask : note

    task automatic wr(logic [7:0] code, logic [15:0] data);
        cmd_wr_i <= 1'b1;
        cmd_i    <= '{code, data};
        tick(1);
        cmd_wr_i <= 1'b0;
        tick(1);
    endtask : wr

    // read data shows one cycle after the code is presented
    task automatic rd(logic [7:0] code, logic [15:0] val);
        rd_code_i <= code;
        tick(1);
        note(0, val, "read data");
        tick(1);
    endtask : rd

    task automatic fault_case(logic [1:0] rs, logic [2:0] r, logic [2:0] u);
        wr(CMD_UC_FAULT_ACTION, {8'h00, rs, r, u});
        load    <= LOW;
        att_clr <= 1'b1;
        tick(2);
        att_clr <= 1'b0;
        note(2, 16'h0, "alert not low");
        note(3, 16'h1, "status not set");
        note(1, {15'h0, ~rs[1]}, "output state at fault");
        if (rs == RESP_CONTINUE) begin
            tick(CU * u - 6);
            note(1, 16'h1, "output dropped in delay");
            tick(10);
            note(1, 16'h0, "output kept after delay");
        end
        if (rs == RESP_DIS_RETRY) begin
            tick(RU * u - 4);
            note(1, 16'h0, "restart too early");
        end
        if (rs == RESP_IGNORE || rs == RESP_DIS_OK) begin
            load <= HI;
            tick(4);
            note(1, 16'h1, "output not running");
            note(3, 16'h1, "status not sticky");
        end else begin
            tick((r + 1) * (RU * u + 6) + 8);
            if (r == RETRY_FOREVER) begin
                note(5, 16'h1, "attempts stopped");
            end else begin
                note(4, {13'h0, r}, "attempt count");
            end
            load <= HI;
            if (r == RETRY_FOREVER) output_enable_i <= 1'b0;
            tick(RU * u + 6);
            note(1, 16'h0, "output not held off");
            output_enable_i <= 1'b1;
        end
        clear_faults_i <= 1'b1;
        tick(1);
        clear_faults_i <= 1'b0;
        tick(3);
        note(3, 16'h0, "status not cleared");
        note(2, 16'h1, "alert not released");
        note(1, 16'h1, "output not restored");
        tick(1);
        $display("test response %b retries %0d units %0d done", rs, r, u);
    endtask : fault_case

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rnd = $urandom(32'h2dcd_1265);
        tick(4);
        sys_rst_i <= 1'b0;
        tick(2);
        rd(CMD_OC_WARN_THRESH, OC_WARN_RST);
        rd(CMD_UC_FAULT_THRESH, UC_THRESH_RST);
        rd(CMD_UC_FAULT_ACTION, {8'h00, UC_ACTION_RST});
        rnd  = $urandom();
        rnd2 = $urandom();
        wr(CMD_OC_WARN_THRESH, rnd[15:0]);
        wr(CMD_UC_FAULT_THRESH, rnd[31:16]);
        note(6, rnd[15:0], "warning threshold port");
        note(7, rnd[31:16], "fault threshold port");
        wr(CMD_UC_FAULT_ACTION, rnd2[15:0]);
        wr(8'h4D, rnd2[31:16]);
        rd(CMD_OC_WARN_THRESH, rnd[15:0]);
        rd(CMD_UC_FAULT_THRESH, rnd[31:16]);
        rd(CMD_UC_FAULT_ACTION, {8'h00, rnd2[7:0]});
        rd(8'h4D, 16'h0000);
        $display("test registers done");
        wr(CMD_UC_FAULT_THRESH, LIM);
        load <= HI;
        tick(2);
        fault_case(RESP_IGNORE, 3'd1, 3'd1);
        fault_case(RESP_DIS_OK, 3'd1, 3'd1);
        fault_case(RESP_CONTINUE, 3'd1, 3'd2);
        for (int i = 0; i < 9; i++) begin
            fault_case(RESP_DIS_RETRY, rlist[i], 3'(i % 3 + 1));
        end
        wr(CMD_UC_FAULT_ACTION, {8'h00, RESP_DIS_RETRY, 3'd1, 3'd0});
        load <= LOW;
        tick(2);
        note(1, 16'h1, "zero interval attempt late");
        tick(1);
        note(1, 16'h0, "failed attempt not latched");
        load           <= HI;
        clear_faults_i <= 1'b1;
        tick(1);
        clear_faults_i <= 1'b0;
        tick(2);
        note(1, 16'h1, "output not restored");
        $display("test zero interval done");
        finish_test();
    end

endmodule : uchf_handler_test

`default_nettype wire

// >>> sim/uchf_load_model.sv
// load current comparator model feeding the fault input
`default_nettype none

module uchf_load_model (
    input  wire logic [15:0] load_i,
    input  wire logic [15:0] uc_threshold_i,
    output logic             uc_fault_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // fault while the load sits below the programmed limit
    assign uc_fault_o = (load_i < uc_threshold_i);

endmodule : uchf_load_model

`default_nettype wire

// >>> verilog/uchf_handler.sv
// output under-current fault handler with limit registers
// ------------------------------------------------------------
// What this block does
// - holds a 16-bit linear-format over-current warning threshold at 0x4A.
// - holds a 16-bit linear-format under-current fault threshold at 0x4B.
// - an under-current fault sets the dedicated under-current status bit.
// - every response mode pulls the alert low and sets the status bit.
// - response 00 keeps the output running through the fault.
// - response 01 runs for the delay, then follows the retry setting if fault remains.
// - response 10 disables output at once, then follows the retry setting.
// - response 11 holds output off only while the fault persists.
// - retry setting 000 makes no restart; output stays off until cleared.
// - settings 001 to 110 allow one to six restarts, then latch off.
// - setting 111 retries without limit until output is commanded off.
// - restart attempts start one programmed interval apart.
// - continue delay uses 10 ms units, restart interval 8.2 ms units.
// - the time field is a direct count of zero to seven units.
// ------------------------------------------------------------
`default_nettype none

module uchf_handler
    import uchf_pkg::*;
#(
    parameter int unsigned CONT_UNIT_CYCLES  = CONT_UNIT_CYC,
    parameter int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cmd_wr_i,
    input  wire uchf_cmd_t   cmd_i,
    input  wire logic [7:0]  rd_code_i,
    output logic      [15:0] rd_data_o,
    input  wire logic        output_enable_i,
    input  wire logic        uc_fault_i,
    input  wire logic        clear_faults_i,
    output logic             output_on_o,
    output logic             alert_output_n_o,
    output logic             uc_status_o,
    output logic      [15:0] oc_warn_threshold_o,
    output logic      [15:0] uc_threshold_o
);

    localparam int UMAX = (CONT_UNIT_CYCLES > RETRY_UNIT_CYCLES) ?
                          CONT_UNIT_CYCLES : RETRY_UNIT_CYCLES;
    localparam int CW   = $clog2(UMAX + 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic on_state(input uchf_state_t s);
        on_state = (s == ST_NORMAL) || (s == ST_CONT) || (s == ST_ATTEMPT);
    endfunction : on_state

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0]  oc_warn_q;
    logic [15:0]  uc_thresh_q;
    logic [7:0]   action_q;
    logic [15:0]  rd_data_q;
    logic [15:0]  rd_data_d;
    uchf_action_t act;

    wire wr_warn   = cmd_wr_i && (cmd_i.code == CMD_OC_WARN_THRESH);
    wire wr_thresh = cmd_wr_i && (cmd_i.code == CMD_UC_FAULT_THRESH);
    wire wr_action = cmd_wr_i && (cmd_i.code == CMD_UC_FAULT_ACTION);

    assign act.resp    = action_q[RESP_MSB:RESP_LSB];
    assign act.retries = action_q[RETRY_MSB:RETRY_LSB];
    assign act.units   = action_q[TIME_MSB:TIME_LSB];

    always_comb begin
        if (rd_code_i == CMD_OC_WARN_THRESH) begin
            rd_data_d = oc_warn_q;
        end else if (rd_code_i == CMD_UC_FAULT_THRESH) begin
            rd_data_d = uc_thresh_q;
        end else if (rd_code_i == CMD_UC_FAULT_ACTION) begin
            rd_data_d = {8'h00, action_q};
        end else begin
            rd_data_d = 16'h0000;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            oc_warn_q   <= OC_WARN_RST;
            uc_thresh_q <= UC_THRESH_RST;
            action_q    <= UC_ACTION_RST;
            rd_data_q   <= 16'h0000;
        end else begin
            if (wr_warn) oc_warn_q <= cmd_i.data;
            if (wr_thresh) uc_thresh_q <= cmd_i.data;
            if (wr_action) action_q <= cmd_i.data[7:0];
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o           = rd_data_q;
    assign oc_warn_threshold_o = oc_warn_q;
    assign uc_threshold_o      = uc_thresh_q;

    // ------------------------------------------------------------
    // status and alert
    // ------------------------------------------------------------
    logic uc_status_q;
    logic fault_prev_q;
    wire  fault_rise = uc_fault_i && !fault_prev_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            uc_status_q  <= 1'b0;
            fault_prev_q <= 1'b0;
        end else begin
            // set wins over clear
            uc_status_q  <= uc_fault_i || (uc_status_q && !clear_faults_i);
            fault_prev_q <= uc_fault_i;
        end
    end

    assign uc_status_o      = uc_status_q;
    assign alert_output_n_o = !uc_status_q;

    // ------------------------------------------------------------
    // unit timer
    // ------------------------------------------------------------
    uchf_state_t state_q;
    uchf_state_t state_d;
    logic [CW-1:0] cyc_q;
    logic [2:0]    units_q;

    wire [CW-1:0] unit_last = (state_q == ST_CONT) ?
                              CW'(CONT_UNIT_CYCLES - 1) :
                              CW'(RETRY_UNIT_CYCLES - 1);
    wire timer_clr  = (state_d != state_q);
    wire timer_done = (units_q == act.units);
    wire unit_tick  = (cyc_q == unit_last);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cyc_q   <= '0;
            units_q <= 3'h0;
        end else if (timer_clr) begin
            cyc_q   <= '0;
            units_q <= 3'h0;
        end else if (!timer_done) begin
            cyc_q   <= unit_tick ? '0 : cyc_q + CW'(1);
            units_q <= unit_tick ? units_q + 3'h1 : units_q;
        end
    end

    // ------------------------------------------------------------
    // response state machine
    // ------------------------------------------------------------
    logic [2:0] att_q;
    logic [2:0] att_d;

    wire uchf_state_t retry_entry = (act.retries == RETRY_NONE) ?
                                    ST_LATCHED : ST_OFF_WAIT;
    wire retries_spent = (act.retries != RETRY_FOREVER) &&
                         (att_q >= act.retries);

    always_comb begin
        state_d = state_q;
        att_d   = att_q;
        if (!output_enable_i) begin
            state_d = ST_NORMAL;
            att_d   = 3'h0;
        end else begin
            case (state_q)
                ST_NORMAL: begin
                    if (fault_rise) begin
                        case (act.resp)
                            RESP_CONTINUE:  state_d = ST_CONT;
                            RESP_DIS_RETRY: state_d = retry_entry;
                            RESP_DIS_OK:    state_d = ST_DIS_OK;
                            default:        state_d = ST_NORMAL;
                        endcase
                    end
                end
                ST_CONT: begin
                    if (timer_done) begin
                        state_d = uc_fault_i ? retry_entry : ST_NORMAL;
                    end
                end
                ST_OFF_WAIT: begin
                    if (timer_done) begin
                        state_d = ST_ATTEMPT;
                        att_d   = (att_q == 3'h7) ? att_q : att_q + 3'h1;
                    end
                end
                ST_ATTEMPT: begin
                    if (uc_fault_i) begin
                        state_d = retries_spent ? ST_LATCHED : ST_OFF_WAIT;
                    end else if (timer_done) begin
                        state_d = ST_NORMAL;
                        att_d   = 3'h0;
                    end
                end
                ST_LATCHED: begin
                    if (clear_faults_i) begin
                        state_d = ST_NORMAL;
                        att_d   = 3'h0;
                    end
                end
                ST_DIS_OK: begin
                    if (!uc_fault_i) state_d = ST_NORMAL;
                end
                default: begin
                    state_d = ST_NORMAL;
                end
            endcase
        end
    end

    logic output_on_q;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q     <= ST_NORMAL;
            att_q       <= 3'h0;
            output_on_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            att_q       <= att_d;
            output_on_q <= output_enable_i && on_state(state_d);
        end
    end

    assign output_on_o = output_on_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    warn_write_a: assert property (wr_warn |=> oc_warn_q == $past(cmd_i.data))
        else $error("warning threshold not stored");

    uc_write_a: assert property (wr_thresh |=> uc_thresh_q == $past(cmd_i.data))
        else $error("fault threshold not stored");

    status_alert_a: assert property (uc_fault_i |=> uc_status_o && !alert_output_n_o)
        else $error("fault did not raise status and alert");

    status_sticky_a: assert property (uc_status_q && !clear_faults_i |=> uc_status_q)
        else $error("status bit lost without clear");

    ignore_runs_a: assert property (state_q == ST_NORMAL && fault_rise
        && output_enable_i && act.resp == RESP_IGNORE
        |=> output_on_o && state_q == ST_NORMAL)
        else $error("ignore mode interrupted output");

    cont_runs_a: assert property (state_q == ST_CONT && output_enable_i
        |=> output_on_o || !$past(output_enable_i) || state_q != ST_CONT)
        else $error("output dropped during continue delay");

    disable_now_a: assert property (state_q == ST_NORMAL && fault_rise
        && output_enable_i && act.resp == RESP_DIS_RETRY |=> !output_on_o)
        else $error("output not disabled at once");

    resume_ok_a: assert property (state_q == ST_DIS_OK && output_enable_i
        && !uc_fault_i |=> state_q == ST_NORMAL ##1 output_on_o)
        else $error("output did not resume after fault cleared");

    no_retry_a: assert property (state_q == ST_NORMAL && fault_rise
        && output_enable_i && act.resp == RESP_DIS_RETRY && act.retries == RETRY_NONE
        |=> state_q == ST_LATCHED)
        else $error("restart attempted with retries off");

    latch_hold_a: assert property (state_q == ST_LATCHED && output_enable_i
        && !clear_faults_i |=> state_q == ST_LATCHED && !output_on_o)
        else $error("latched output left off state");

    attempt_cap_a: assert property (act.retries != RETRY_FOREVER && !wr_action
        && state_q == ST_ATTEMPT |-> att_q <= act.retries)
        else $error("attempt count above retry setting");

    forever_retry_a: assert property (state_q == ST_ATTEMPT && uc_fault_i
        && output_enable_i && act.retries == RETRY_FOREVER |=> state_q == ST_OFF_WAIT)
        else $error("unlimited retry stopped");

    zero_units_a: assert property (state_q == ST_OFF_WAIT && act.units == 3'h0
        && output_enable_i |=> state_q == ST_ATTEMPT)
        else $error("zero interval not immediate");

    enable_reset_a: assert property (!output_enable_i |=> att_q == 3'h0
        && state_q == ST_NORMAL)
        else $error("counters not reset on disable");

endmodule : uchf_handler

`default_nettype wire

// >>> verilog/uchf_pkg.sv
// constants and types of the output under-current fault handler
`default_nettype none

package uchf_pkg;

    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_OC_WARN_THRESH  = 8'h4A;
    localparam logic [7:0]  CMD_UC_FAULT_THRESH = 8'h4B;
    localparam logic [7:0]  CMD_UC_FAULT_ACTION = 8'h4C;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] OC_WARN_RST   = 16'h0000;
    localparam logic [15:0] UC_THRESH_RST = 16'h0000;
    localparam logic [7:0]  UC_ACTION_RST = 8'h00;

    // ------------------------------------------------------------
    // action byte fields
    // ------------------------------------------------------------
    localparam int RESP_MSB  = 7;
    localparam int RESP_LSB  = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int TIME_MSB  = 2;
    localparam int TIME_LSB  = 0;

    localparam logic [1:0] RESP_IGNORE    = 2'h0;
    localparam logic [1:0] RESP_CONTINUE  = 2'h1;
    localparam logic [1:0] RESP_DIS_RETRY = 2'h2;
    localparam logic [1:0] RESP_DIS_OK    = 2'h3;
    localparam logic [2:0] RETRY_NONE     = 3'h0;
    localparam logic [2:0] RETRY_FOREVER  = 3'h7;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam real CLK_MHZ          = 100.0;
    localparam real CONT_UNIT_MS     = 10.0;
    localparam real RETRY_UNIT_MS    = 8.2;
    localparam int  CONT_UNIT_CYC    = int'(CONT_UNIT_MS * 1000.0 * CLK_MHZ);
    localparam int  RETRY_UNIT_CYC   = int'(RETRY_UNIT_MS * 1000.0 * CLK_MHZ);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] resp;
        logic [2:0] retries;
        logic [2:0] units;
    } uchf_action_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] data;
    } uchf_cmd_t;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_CONT,
        ST_OFF_WAIT,
        ST_ATTEMPT,
        ST_LATCHED,
        ST_DIS_OK
    } uchf_state_t;

endpackage : uchf_pkg

`default_nettype wire
